// >>> ilb_map.svh
// constants of the interprocessor link buffer: addresses, reset values, counts
`ifndef ILB_MAP_SVH
`define ILB_MAP_SVH

// shared store is reached with the low address lines only
`define ILB_ADDR_W 11
// mailbox written by the upstream end, read by the downstream end
`define ILB_MBOX_DOWN 11'h3FE
// mailbox written by the downstream end, read by the upstream end
`define ILB_MBOX_UP 11'h3FF
// latch and queue ignore the address; the processor puts this one out on its write port, its read port always uses ILB_MBOX_DOWN
`define ILB_DATA_ADDR 11'h000

`define ILB_WIDTH_DEF 40
`define ILB_SLICE_W 8
`define ILB_QUEUE_DEPTH 16
// burst loop length on the queue, in cycles
`define ILB_LOOP_LEN 5

// semaphore state after reset: empty, writer allowed
`define ILB_RST_READY 1'b0
`define ILB_RST_ACK 1'b1
`define ILB_RST_BUSY_N 1'b1

`endif

// >>> ilb_pkg.sv
// types shared by both ends of the interprocessor link buffer
package ilb_pkg;

   typedef enum logic [1:0] {
      ILB_LATCH,
      ILB_QUEUE,
      ILB_DUALPORT
   } ilb_variant_t;

   typedef enum logic [1:0] {
      ILB_WS_IDLE,
      ILB_WS_STROBE,
      ILB_WS_GAP
   } ilb_wstate_t;

   typedef enum logic [1:0] {
      ILB_RS_IDLE,
      ILB_RS_STROBE,
      ILB_RS_REPLY
   } ilb_rstate_t;

endpackage : ilb_pkg

// >>> ilb_link_if.sv
// one link between an upstream and a downstream processor and their buffer
`include "ilb_map.svh"

interface ilb_link_if #(
   parameter int WIDTH = `ILB_WIDTH_DEF
) (
   input wire logic CLK
);
   // upstream processor, data-side write port
   logic [WIDTH-1:0] data_side_data_bus;
   logic [`ILB_ADDR_W-1:0] wr_addr;
   logic data_side_write_strobe_n;
   logic wr_data_bank_one_select_n;
   // downstream processor, read port
   logic [`ILB_ADDR_W-1:0] rd_addr;
   logic program_side_read_strobe_n;
   logic program_bank_one_select_n;
   logic rd_data_bank_one_select_n;
   logic [WIDTH-1:0] program_side_data_bus;
   logic rd_oe_n;
   // downstream processor, write-back port of the dual-port store
   logic [WIDTH-1:0] pw_data;
   logic [`ILB_ADDR_W-1:0] pw_addr;
   logic pw_strobe_n;
   // semaphores and status from the buffer
   logic read_acknowledge_flag_input;
   logic data_ready_flag_input;
   logic contention_n;

   modport proc_wr (
      output data_side_data_bus,
      output wr_addr,
      output data_side_write_strobe_n,
      output wr_data_bank_one_select_n,
      input read_acknowledge_flag_input
   );

   modport proc_rd (
      output rd_addr,
      output program_side_read_strobe_n,
      output program_bank_one_select_n,
      output rd_data_bank_one_select_n,
      output pw_data,
      output pw_addr,
      output pw_strobe_n,
      input program_side_data_bus,
      input rd_oe_n,
      input data_ready_flag_input,
      input contention_n
   );

   modport buffer (
      input data_side_data_bus,
      input wr_addr,
      input data_side_write_strobe_n,
      input wr_data_bank_one_select_n,
      input rd_addr,
      input program_side_read_strobe_n,
      input program_bank_one_select_n,
      input rd_data_bank_one_select_n,
      input pw_data,
      input pw_addr,
      input pw_strobe_n,
      output program_side_data_bus,
      output rd_oe_n,
      output read_acknowledge_flag_input,
      output data_ready_flag_input,
      output contention_n
   );
endinterface : ilb_link_if

// >>> ilb_proc_end.sv
// processor end: drives one downstream link and reads one upstream link
`include "ilb_map.svh"

module ilb_proc_end
   import ilb_pkg::*;
#(
   parameter int WIDTH = `ILB_WIDTH_DEF,
   parameter ilb_variant_t VARIANT = ILB_LATCH,
   parameter bit IN_ON_DATA = 1'b0,
   parameter int LOOP_LEN = `ILB_LOOP_LEN
) (
   input wire logic CLK,
   input wire logic RST,
   ilb_link_if.proc_wr DN,
   ilb_link_if.proc_rd UP,
   input wire logic SEND_VALID,
   input wire logic [WIDTH-1:0] SEND_DATA,
   output logic SEND_TAKEN,
   output logic RECV_VALID,
   output logic [WIDTH-1:0] RECV_DATA,
   output logic CONTENTION_SEEN
);
   localparam int GAP_N = (VARIANT == ILB_QUEUE) ? LOOP_LEN - 2 : 0;
   localparam int GW = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // send side
   ilb_wstate_t ws_ff, nxt_ws;
   logic [GW-1:0] gap_ff, nxt_gap;
   logic wstb_n_ff, nxt_wstb_n;
   logic [WIDTH-1:0] wdata_ff, nxt_wdata;
   logic [`ILB_ADDR_W-1:0] waddr_ff, nxt_waddr;
   logic taken_ff, nxt_taken;

   always_comb begin
      nxt_ws = ws_ff;
      nxt_gap = gap_ff;
      nxt_wstb_n = 1'b1;
      nxt_wdata = wdata_ff;
      nxt_waddr = waddr_ff;
      nxt_taken = 1'b0;
      unique case (ws_ff)
         ILB_WS_IDLE: begin
            // flag sampled only here, never in the strobe cycle where it is stale
            if (SEND_VALID && DN.read_acknowledge_flag_input) begin // R8 R10 R13
               nxt_ws = ILB_WS_STROBE;
               nxt_wstb_n = 1'b0; // R2
               nxt_wdata = SEND_DATA;
               nxt_waddr = (VARIANT == ILB_DUALPORT) ? `ILB_MBOX_DOWN : `ILB_DATA_ADDR; // R19 R20
               nxt_taken = 1'b1;
            end
         end
         ILB_WS_STROBE: begin
            if (GAP_N > 0) begin // R15
               nxt_ws = ILB_WS_GAP;
               nxt_gap = GW'(GAP_N - 1);
            end else begin
               nxt_ws = ILB_WS_IDLE;
            end
         end
         ILB_WS_GAP: begin
            if (gap_ff == '0) begin
               nxt_ws = ILB_WS_IDLE;
            end else begin
               nxt_gap = gap_ff - GW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ws_ff <= ILB_WS_IDLE;
         gap_ff <= '0;
         wstb_n_ff <= 1'b1;
         wdata_ff <= '0;
         waddr_ff <= '0;
         taken_ff <= 1'b0;
      end else begin
         ws_ff <= nxt_ws;
         gap_ff <= nxt_gap;
         wstb_n_ff <= nxt_wstb_n;
         wdata_ff <= nxt_wdata;
         waddr_ff <= nxt_waddr;
         taken_ff <= nxt_taken;
      end
   end

   assign DN.data_side_data_bus = wdata_ff;
   assign DN.wr_addr = waddr_ff;
   assign DN.data_side_write_strobe_n = wstb_n_ff;
   assign DN.wr_data_bank_one_select_n = wstb_n_ff; // R3
   assign SEND_TAKEN = taken_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // receive side
   ilb_rstate_t rs_ff, nxt_rs;
   logic rstb_n_ff, nxt_rstb_n;
   logic pstb_n_ff, nxt_pstb_n;
   logic [WIDTH-1:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic cont_ff, nxt_cont;

   always_comb begin
      nxt_rs = rs_ff;
      nxt_rstb_n = 1'b1;
      nxt_pstb_n = 1'b1;
      nxt_rdata = rdata_ff;
      nxt_rvalid = 1'b0;
      nxt_cont = cont_ff | ~UP.contention_n;
      unique case (rs_ff)
         ILB_RS_IDLE: begin
            if (UP.data_ready_flag_input) begin // R8 R9 R14 R17
               nxt_rs = ILB_RS_STROBE;
               nxt_rstb_n = 1'b0;
            end
         end
         ILB_RS_STROBE: begin
            nxt_rdata = UP.program_side_data_bus; // R2
            nxt_rvalid = 1'b1;
            if (VARIANT == ILB_DUALPORT) begin
               // echo into the mailbox the upstream end reads, never into one it writes
               nxt_rs = ILB_RS_REPLY;
               nxt_pstb_n = 1'b0; // R19
            end else begin
               nxt_rs = ILB_RS_IDLE;
            end
         end
         ILB_RS_REPLY: begin
            nxt_rs = ILB_RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rs_ff <= ILB_RS_IDLE;
         rstb_n_ff <= 1'b1;
         pstb_n_ff <= 1'b1;
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
         cont_ff <= 1'b0;
      end else begin
         rs_ff <= nxt_rs;
         rstb_n_ff <= nxt_rstb_n;
         pstb_n_ff <= nxt_pstb_n;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         cont_ff <= nxt_cont;
      end
   end

   assign UP.rd_addr = `ILB_MBOX_DOWN;
   assign UP.program_side_read_strobe_n = rstb_n_ff;
   assign UP.program_bank_one_select_n = IN_ON_DATA ? 1'b1 : rstb_n_ff; // R12
   assign UP.rd_data_bank_one_select_n = IN_ON_DATA ? rstb_n_ff : 1'b1; // R12
   assign UP.pw_data = rdata_ff;
   assign UP.pw_addr = `ILB_MBOX_UP;
   assign UP.pw_strobe_n = pstb_n_ff;
   assign RECV_VALID = rvalid_ff;
   assign RECV_DATA = rdata_ff;
   assign CONTENTION_SEEN = cont_ff;

endmodule : ilb_proc_end

// >>> ilb_buffer_end.sv
// buffer end: latch, queue or dual-port store with its semaphore logic
// Function
// R1: buffer width 8 to 40 in byte slices
// R2: writer uses data bus, reader program bus
// R3: bank-one selects qualify every access; the dual-port write-back (pw_strobe_n) has no select and is not qualified
// R4: capture at write strobe end, drive on read
// R5: write sets semaphore, raises data ready
// R6: read clears data ready, raises acknowledge
// R7: next write drops writer acknowledge
// R8: both flags are inputs on each processor
// R9: read only while data ready set
// R10: write only while acknowledge set
// R11: read allowed the cycle after write
// R12: input side may use data bus instead
// R13: queue full pulls writer acknowledge low
// R14: queue empty drops reader data ready
// R15: burst write loop spans five cycles
// R16: mailbox write raises notification
// R17: receiver reads mailbox when notified
// R18: same-address dual write flags contention
// R19: each side writes only what other reads
// R20: shared store uses low eleven address bits
// R21: reset empties semaphores, acknowledge high
`include "ilb_map.svh"

module ilb_buffer_end
   import ilb_pkg::*;
#(
   parameter int WIDTH = `ILB_WIDTH_DEF,
   parameter ilb_variant_t VARIANT = ILB_LATCH,
   parameter bit IN_ON_DATA = 1'b0,
   parameter int DEPTH = `ILB_QUEUE_DEPTH
) (
   input wire logic CLK,
   input wire logic RST,
   ilb_link_if.buffer LNK
);
   // width must be a whole number of byte slices
   localparam int SLICES = WIDTH / `ILB_SLICE_W;
   localparam int AW = `ILB_ADDR_W;
   localparam int MEMN = (VARIANT == ILB_DUALPORT) ? (1 << AW) : DEPTH;
   localparam int MW = $clog2(MEMN);
   // queue pointers wrap naturally, so DEPTH must be a power of two
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   function automatic logic is_mbox(input logic [AW-1:0] a);
      is_mbox = (a == `ILB_MBOX_DOWN) || (a == `ILB_MBOX_UP);
   endfunction : is_mbox

   ////////////////////////////////////////////////////////////////////////////////
   // access decode
   logic wr_acc;
   logic rd_sel;
   logic rd_acc;
   logic pw_acc;

   assign wr_acc = ~LNK.data_side_write_strobe_n & ~LNK.wr_data_bank_one_select_n; // R3
   assign rd_sel = IN_ON_DATA ? ~LNK.rd_data_bank_one_select_n
                              : ~LNK.program_bank_one_select_n; // R3 R12
   assign rd_acc = ~LNK.program_side_read_strobe_n & rd_sel;
   assign pw_acc = ~LNK.pw_strobe_n & (VARIANT == ILB_DUALPORT);

   ////////////////////////////////////////////////////////////////////////////////
   // storage and semaphores
   logic [WIDTH-1:0] mem [MEMN];
   logic [WIDTH-1:0] latch_ff, nxt_latch;
   logic full_ff, nxt_full;
   logic [PW-1:0] wptr_ff, nxt_wptr;
   logic [PW-1:0] rptr_ff, nxt_rptr;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic note_ff, nxt_note;
   logic reply_ff, nxt_reply;
   logic ready_ff, nxt_ready;
   logic ack_ff, nxt_ack;
   logic busy_n_ff, nxt_busy_n;
   logic we_a, we_b;
   logic [MW-1:0] wa_a, wa_b;
   logic push, pop;

   always_comb begin
      nxt_latch = latch_ff;
      nxt_full = full_ff;
      nxt_wptr = wptr_ff;
      nxt_rptr = rptr_ff;
      nxt_cnt = cnt_ff;
      nxt_note = note_ff;
      nxt_reply = reply_ff;
      nxt_busy_n = 1'b1;
      we_a = 1'b0;
      we_b = 1'b0;
      wa_a = '0;
      wa_b = '0;
      push = 1'b0;
      pop = 1'b0;
      nxt_ready = ready_ff;
      nxt_ack = ack_ff;
      unique case (VARIANT)
         ILB_LATCH: begin
            // the clear is applied first so a write in the same cycle wins
            if (rd_acc) begin
               nxt_full = 1'b0; // R6
            end
            if (wr_acc) begin
               for (int s = 0; s < SLICES; s++) begin
                  nxt_latch[s*`ILB_SLICE_W +: `ILB_SLICE_W] =
                     LNK.data_side_data_bus[s*`ILB_SLICE_W +: `ILB_SLICE_W]; // R1 R4
               end
               nxt_full = 1'b1; // R5 R7
            end
            nxt_ready = nxt_full; // R5 R6 R11
            nxt_ack = ~nxt_full; // R6 R7
         end
         ILB_QUEUE: begin
            // a write into a full queue is dropped; the writer is told by the flag
            push = wr_acc && (cnt_ff != FULL_CNT);
            pop = rd_acc && (cnt_ff != '0);
            we_a = push;
            wa_a = MW'(wptr_ff);
            nxt_wptr = wptr_ff + PW'(push);
            nxt_rptr = rptr_ff + PW'(pop);
            nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
            nxt_ready = (nxt_cnt != '0); // R14
            nxt_ack = (nxt_cnt != FULL_CNT); // R13
         end
         ILB_DUALPORT: begin
            we_a = wr_acc;
            wa_a = MW'(LNK.wr_addr); // R20
            wa_b = MW'(LNK.pw_addr);
            // port a wins a same-address collision; port b's word is lost
            if (wr_acc && pw_acc && (LNK.wr_addr == LNK.pw_addr)) begin
               nxt_busy_n = 1'b0; // R18
            end else begin
               we_b = pw_acc;
            end
            if (rd_acc && is_mbox(LNK.rd_addr)) begin
               nxt_note = 1'b0; // R17
            end
            if (wr_acc && is_mbox(LNK.wr_addr)) begin
               nxt_note = 1'b1; // R16
               nxt_reply = 1'b0;
            end
            if (we_b && is_mbox(LNK.pw_addr)) begin
               nxt_reply = 1'b1; // R16
            end
            nxt_ready = nxt_note;
            nxt_ack = nxt_reply;
         end
         default: begin
            nxt_ready = `ILB_RST_READY;
            nxt_ack = `ILB_RST_ACK;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         latch_ff <= '0;
         full_ff <= 1'b0;
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
         note_ff <= 1'b0;
         reply_ff <= `ILB_RST_ACK;
         ready_ff <= `ILB_RST_READY; // R21
         ack_ff <= `ILB_RST_ACK; // R21
         busy_n_ff <= `ILB_RST_BUSY_N;
      end else begin
         latch_ff <= nxt_latch;
         full_ff <= nxt_full;
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         cnt_ff <= nxt_cnt;
         note_ff <= nxt_note;
         reply_ff <= nxt_reply;
         ready_ff <= nxt_ready;
         ack_ff <= nxt_ack;
         busy_n_ff <= nxt_busy_n;
      end
   end

   // store has no reset; its contents are only read behind a set semaphore
   always_ff @(posedge CLK) begin
      if (we_a) begin
         mem[wa_a] <= LNK.data_side_data_bus;
      end
      if (we_b) begin
         mem[wa_b] <= LNK.pw_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path
   logic [WIDTH-1:0] rd_word;

   always_comb begin
      rd_word = '0;
      unique case (VARIANT)
         ILB_LATCH: begin
            rd_word = latch_ff;
         end
         ILB_QUEUE: begin
            rd_word = mem[MW'(rptr_ff)];
         end
         ILB_DUALPORT: begin
            rd_word = mem[MW'(LNK.rd_addr)]; // R20
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // bus is driven only during the read strobe; zero elsewhere stands for release
   assign LNK.program_side_data_bus = rd_acc ? rd_word : '0; // R4
   assign LNK.rd_oe_n = ~rd_acc; // R4
   assign LNK.data_ready_flag_input = ready_ff;
   assign LNK.read_acknowledge_flag_input = ack_ff;
   assign LNK.contention_n = busy_n_ff;

endmodule : ilb_buffer_end

// >>> ilb_dummy_end_marker_not_used.sv
// intentionally minimal: no content beyond this header line

// >>> ilb_link_asserts.sv
// concurrent checks on one latch link between two processor ends
`include "ilb_map.svh"
module ilb_link_asserts #(
   parameter int WIDTH = `ILB_WIDTH_DEF
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [WIDTH-1:0] data_side_data_bus,
   input wire logic data_side_write_strobe_n,
   input wire logic wr_data_bank_one_select_n,
   input wire logic program_side_read_strobe_n,
   input wire logic program_bank_one_select_n,
   input wire logic rd_data_bank_one_select_n,
   input wire logic [WIDTH-1:0] program_side_data_bus,
   input wire logic rd_oe_n,
   input wire logic read_acknowledge_flag_input,
   input wire logic data_ready_flag_input
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   logic rd;
   logic [WIDTH-1:0] held_ff;
   logic [WIDTH-1:0] nxt_held;
   assign wr = !data_side_write_strobe_n;
   assign rd = !program_side_read_strobe_n;
   ////////////////////////////////////////////////////////////////
   // shadow of the latch contents, taken when the write strobe ends
   always_comb begin
      nxt_held = wr ? data_side_data_bus : held_ff;
   end
   always_ff @(posedge CLK) begin
      held_ff <= RST ? '0 : nxt_held;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_sel_with_strobe;
      (wr |-> !wr_data_bank_one_select_n) and (rd |-> !program_bank_one_select_n);
   endproperty
   a_sel_with_strobe: assert property (p_sel_with_strobe) else $error("select missing");
   property p_prog_side_read;
      rd |-> rd_data_bank_one_select_n;
   endproperty
   a_prog_side_read: assert property (p_prog_side_read) else $error("wrong read select");
   property p_wr_gated;
      wr |-> read_acknowledge_flag_input;
   endproperty
   a_wr_gated: assert property (p_wr_gated) else $error("write without ack");
   property p_rd_gated;
      rd |-> data_ready_flag_input;
   endproperty
   a_rd_gated: assert property (p_rd_gated) else $error("read without ready");
   property p_wr_sets;
      wr |=> data_ready_flag_input && !read_acknowledge_flag_input;
   endproperty
   a_wr_sets: assert property (p_wr_sets) else $error("write left flags wrong");
   property p_rd_clears;
      rd |=> !data_ready_flag_input && read_acknowledge_flag_input;
   endproperty
   a_rd_clears: assert property (p_rd_clears) else $error("read left flags wrong");
   property p_rd_drive;
      rd |-> !rd_oe_n && program_side_data_bus == held_ff;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read data wrong");
   property p_no_drive;
      !rd |-> rd_oe_n && program_side_data_bus == '0;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("bus driven outside read");
   // reader is idle while the latch is empty, so it must follow at once
   property p_next_rd;
      wr |=> !wr ##[0:1] rd;
   endproperty
   a_next_rd: assert property (p_next_rd) else $error("read did not follow write");
   property p_reset_state;
      $fell(RST) |-> read_acknowledge_flag_input && !data_ready_flag_input;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("flags wrong after reset");
   c_write: cover property (wr);
   c_read_then_write: cover property (rd ##[1:4] wr);
   c_reset_release: cover property ($fell(RST));
endmodule : ilb_link_asserts

// >>> tb_interprocessor_link_buffer.sv
// bench: two ends in a latch ring, plus a queue end and a dual-port end on loopback links
`include "ilb_map.svh"
module tb_interprocessor_link_buffer import ilb_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = `ILB_WIDTH_DEF;
   logic clk;
   logic rst;
   integer seed;
   int mismatches;
   int cmp_count;
   logic a_sv, b_sv, a_tk, b_tk, a_rv, b_rv, a_cs, b_cs;
   logic [W-1:0] a_sd, b_sd, a_rd, b_rd;
   logic [W-1:0] q_ab[$];
   logic [W-1:0] q_ba[$];
   logic q_sv, d_sv, q_tk, d_tk, q_rv, d_rv, q_cs, d_cs;
   logic [W-1:0] q_sd, d_sd, q_rd, d_rd;
   logic [W-1:0] q_qq[$];
   logic [W-1:0] q_dd[$];
   ilb_link_if #(.WIDTH(W)) lnk_ab (.CLK(clk));
   ilb_link_if #(.WIDTH(W)) lnk_ba (.CLK(clk));
   ilb_proc_end #(.WIDTH(W), .VARIANT(ILB_LATCH)) ilb_proc_end_inst0 (.CLK(clk), .RST(rst),
      .DN(lnk_ab.proc_wr), .UP(lnk_ba.proc_rd), .SEND_VALID(a_sv), .SEND_DATA(a_sd),
      .SEND_TAKEN(a_tk), .RECV_VALID(a_rv), .RECV_DATA(a_rd), .CONTENTION_SEEN(a_cs));
   ilb_proc_end #(.WIDTH(W), .VARIANT(ILB_LATCH)) ilb_proc_end_inst1 (.CLK(clk), .RST(rst),
      .DN(lnk_ba.proc_wr), .UP(lnk_ab.proc_rd), .SEND_VALID(b_sv), .SEND_DATA(b_sd),
      .SEND_TAKEN(b_tk), .RECV_VALID(b_rv), .RECV_DATA(b_rd), .CONTENTION_SEEN(b_cs));
   ilb_buffer_end #(.WIDTH(W), .VARIANT(ILB_LATCH)) ilb_buffer_end_inst0 (.CLK(clk),
      .RST(rst), .LNK(lnk_ab.buffer));
   ilb_buffer_end #(.WIDTH(W), .VARIANT(ILB_LATCH)) ilb_buffer_end_inst1 (.CLK(clk),
      .RST(rst), .LNK(lnk_ba.buffer));
   // each end below is looped onto its own link, so it reads back what it wrote
   ilb_link_if #(.WIDTH(W)) lnk_q (.CLK(clk));
   ilb_link_if #(.WIDTH(W)) lnk_d (.CLK(clk));
   ilb_proc_end #(.WIDTH(W), .VARIANT(ILB_QUEUE), .IN_ON_DATA(1'b1)) ilb_proc_end_inst2 (
      .CLK(clk), .RST(rst), .DN(lnk_q.proc_wr), .UP(lnk_q.proc_rd), .SEND_VALID(q_sv),
      .SEND_DATA(q_sd), .SEND_TAKEN(q_tk), .RECV_VALID(q_rv), .RECV_DATA(q_rd),
      .CONTENTION_SEEN(q_cs));
   ilb_buffer_end #(.WIDTH(W), .VARIANT(ILB_QUEUE), .IN_ON_DATA(1'b1)) ilb_buffer_end_inst2 (
      .CLK(clk), .RST(rst), .LNK(lnk_q.buffer));
   ilb_proc_end #(.WIDTH(W), .VARIANT(ILB_DUALPORT)) ilb_proc_end_inst3 (.CLK(clk),
      .RST(rst), .DN(lnk_d.proc_wr), .UP(lnk_d.proc_rd), .SEND_VALID(d_sv),
      .SEND_DATA(d_sd), .SEND_TAKEN(d_tk), .RECV_VALID(d_rv), .RECV_DATA(d_rd),
      .CONTENTION_SEEN(d_cs));
   ilb_buffer_end #(.WIDTH(W), .VARIANT(ILB_DUALPORT)) ilb_buffer_end_inst3 (.CLK(clk),
      .RST(rst), .LNK(lnk_d.buffer));
   ilb_link_asserts #(.WIDTH(W)) ilb_link_asserts_inst (.CLK(clk), .RST(rst),
      .data_side_data_bus(lnk_ab.data_side_data_bus),
      .data_side_write_strobe_n(lnk_ab.data_side_write_strobe_n),
      .wr_data_bank_one_select_n(lnk_ab.wr_data_bank_one_select_n),
      .program_side_read_strobe_n(lnk_ab.program_side_read_strobe_n),
      .program_bank_one_select_n(lnk_ab.program_bank_one_select_n),
      .rd_data_bank_one_select_n(lnk_ab.rd_data_bank_one_select_n),
      .program_side_data_bus(lnk_ab.program_side_data_bus), .rd_oe_n(lnk_ab.rd_oe_n),
      .read_acknowledge_flag_input(lnk_ab.read_acknowledge_flag_input),
      .data_ready_flag_input(lnk_ab.data_ready_flag_input));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   function automatic logic [W-1:0] rnd();
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      return r[W-1:0];
   endfunction : rnd
   ////////////////////////////////////////////////////////////////
   // note the word first, then hold valid until the end reports it taken
   task automatic send(input bit to_b, input logic [W-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      if (to_b) begin
         a_sv <= 1'b1;
         a_sd <= d;
         q_ab.push_back(d);
      end else begin
         b_sv <= 1'b1;
         b_sd <= d;
         q_ba.push_back(d);
      end
      do begin
         @(negedge clk);
         n++;
      end while (((to_b ? a_tk : b_tk) !== 1'b1) && n < 40);
      check(n < 40, 1'b1);
      @(posedge clk);
      if (to_b) a_sv <= 1'b0;
      else b_sv <= 1'b0;
   endtask : send
   // same handshake for the loopback ends: queue when dual is 0, dual-port otherwise
   task automatic send_lb(input bit dual, input logic [W-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      if (dual) begin
         d_sv <= 1'b1;
         d_sd <= d;
         q_dd.push_back(d);
      end else begin
         q_sv <= 1'b1;
         q_sd <= d;
         q_qq.push_back(d);
      end
      do begin
         @(negedge clk);
         n++;
      end while (((dual ? d_tk : q_tk) !== 1'b1) && n < 40);
      check(n < 40, 1'b1);
      @(posedge clk);
      if (dual) d_sv <= 1'b0;
      else q_sv <= 1'b0;
   endtask : send_lb
   task automatic check_idle;
      @(negedge clk);
      check(lnk_ab.read_acknowledge_flag_input, 1'b1);
      check(lnk_ab.data_ready_flag_input, 1'b0);
      check(lnk_ba.read_acknowledge_flag_input, 1'b1);
      check(lnk_ba.data_ready_flag_input, 1'b0);
      check(lnk_q.read_acknowledge_flag_input, 1'b1);
      check(lnk_q.data_ready_flag_input, 1'b0);
      check(lnk_d.read_acknowledge_flag_input, 1'b1);
      check(lnk_d.data_ready_flag_input, 1'b0);
   endtask : check_idle
   // words in flight are lost by a reset, so the notes go too
   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      a_sv <= 1'b0;
      b_sv <= 1'b0;
      q_sv <= 1'b0;
      d_sv <= 1'b0;
      q_ab.delete();
      q_ba.delete();
      q_qq.delete();
      q_dd.delete();
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (rst === 1'b0 && b_rv === 1'b1) begin
         if (q_ab.size() > 0) check(b_rd, q_ab.pop_front());
         else check(1'b1, 1'b0);
      end
      if (rst === 1'b0 && a_rv === 1'b1) begin
         if (q_ba.size() > 0) check(a_rd, q_ba.pop_front());
         else check(1'b1, 1'b0);
      end
      if (rst === 1'b0 && q_rv === 1'b1) begin
         if (q_qq.size() > 0) check(q_rd, q_qq.pop_front());
         else check(1'b1, 1'b0);
      end
      if (rst === 1'b0 && d_rv === 1'b1) begin
         if (q_dd.size() > 0) check(d_rd, q_dd.pop_front());
         else check(1'b1, 1'b0);
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   initial begin
      seed = 32'h02F6C69D;
      mismatches = 0;
      cmp_count = 0;
      rst = 1'b1;
      a_sv = 1'b0;
      b_sv = 1'b0;
      a_sd = '0;
      b_sd = '0;
      q_sv = 1'b0;
      d_sv = 1'b0;
      q_sd = '0;
      d_sd = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      check_idle();
      // boundary words back to back, then random ones
      send(1'b1, '0);
      send(1'b1, {W{1'b1}});
      send(1'b1, 40'h80_0000_0001);
      for (int i = 0; i < 8; i++) send(1'b1, rnd());
      fork
         for (int i = 0; i < 8; i++) send(1'b1, rnd());
         for (int j = 0; j < 8; j++) send(1'b0, rnd());
         for (int k = 0; k < 8; k++) send_lb(1'b0, rnd());
         for (int m = 0; m < 8; m++) send_lb(1'b1, rnd());
      join
      // reset while a word sits in the latch
      @(posedge clk);
      a_sv <= 1'b1;
      a_sd <= rnd();
      repeat (2) @(posedge clk);
      do_reset();
      check_idle();
      send(1'b1, rnd());
      send(1'b0, rnd());
      send_lb(1'b0, rnd());
      send_lb(1'b1, rnd());
      repeat (10) @(posedge clk);
      check(q_ab.size(), 0);
      check(q_ba.size(), 0);
      check(q_qq.size(), 0);
      check(q_dd.size(), 0);
      check(a_cs, 1'b0);
      check(b_cs, 1'b0);
      check(q_cs, 1'b0);
      check(d_cs, 1'b0);
      give_verdict();
   end
endmodule : tb_interprocessor_link_buffer
